// File: fsup_pkg.sv
// Summary of operation
// [RULE1] Flag open coil when its duty stays 100% longer than the selected timeout.
// [RULE2] Check only the current-carrying coil: positions 0,32,64,96 check X,Y,X,Y.
// [RULE3] Open detection sets the per-coil flag and the summary open flag.
// [RULE4] Both reaction bits clear: disable only the affected bridge, motor enable stays.
// [RULE5] Float bit set, reaction-off clear: disable both bridges, clear motor enable.
// [RULE6] Reaction-off set: both drivers stay active after an open detection.
// [RULE7] Overcurrent sets short flag, switches drivers off, clears motor enable.
// [RULE8] Latched short flag per top/bottom transistor; summary is their OR.
// [RULE9] Summary short flag clears when the master reads the short status.
// [RULE10] Master rewrites motor enable; with auto check enabled, diagnostics start first.
// [RULE11] Above warning temperature set warning flag and assert error, motor kept.
// [RULE12] Above shutdown temperature set shutdown flag, error, clear enable, block hard reset.
// [RULE13] Shutdown flag clears only below warning level after it was read.
// [RULE14] Motor enable write of 1 works only when shutdown and warning are 0.
// [RULE15] Clock count not multiple of 16: framing error, error output, no loads.
// [RULE16] Framing error clears only on an error-free frame requesting status 0; the code also clears it in the reset state.
// [RULE17] Error output is the OR of fault flags and reset state, off in sleep.
// [RULE18] Enter sleep after power-on or hard reset, or when sleep bit written 1.
// [RULE19] Sleep: SPI ignored, bridges off, registers kept, hard reset off, thermal frozen.
// [RULE20] Chip select falling edge wakes and clears sleep; master waits the wake time.
// [RULE21] After reset set reset flag, hold error low for reset period, then sleep.
// [RULE22] Five direction patterns in hold, each within trigger time, reset the logic.
// [RULE23] Hold is active when run/hold input XOR its polarity bit is low.
// [RULE24] Count clock edges from chip select fall, judge at chip select rise.
package fsup_pkg;
  localparam int CLK_MHZ = 200;
  localparam int HR_ERR_US = 100;
  localparam int HR_ERR_CYC = HR_ERR_US * CLK_MHZ;
  localparam int WAKE_US = 50;
  localparam int WAKE_CYC = WAKE_US * CLK_MHZ;
  localparam int TRIG_US = 20;
  localparam int TRIG_CYC = TRIG_US * CLK_MHZ;
  localparam int TRIG_W = 12;
  localparam int OPEN_TMO0_MS = 4;
  localparam int OPEN_TMO1_MS = 20;
  localparam int OPEN_TMO2_MS = 40;
  localparam int OPEN_TMO3_MS = 160;
  localparam int OPEN_TMO0_CYC = OPEN_TMO0_MS * 1000 * CLK_MHZ;
  localparam int OPEN_TMO1_CYC = OPEN_TMO1_MS * 1000 * CLK_MHZ;
  localparam int OPEN_TMO2_CYC = OPEN_TMO2_MS * 1000 * CLK_MHZ;
  localparam int OPEN_TMO3_CYC = OPEN_TMO3_MS * 1000 * CLK_MHZ;
  localparam logic [2:0] HR_PATTERNS = 3'h5;
  localparam logic [6:0] MSP_X0 = 7'h00;
  localparam logic [6:0] MSP_Y0 = 7'h20;
  localparam logic [6:0] MSP_X1 = 7'h40;
  localparam logic [6:0] MSP_Y1 = 7'h60;
  localparam int FRAME_W = 4;
  localparam int NUM_SHORT = 8;
  // Short bits 0..3 belong to coil X, 4..7 to coil Y.
  localparam int SY_SHORT = 0;
  localparam int SY_WARN = 8;
  localparam int SY_SHUT = 9;
  localparam int SY_DIR = 10;
  localparam int SY_RH = 11;
  localparam int SY_CS = 12;
  localparam int SY_GRAY = 13;
  localparam int SYNC_W = 17;
  localparam logic [SYNC_W-1:0] SYNC_RST = 17'h01000;

  typedef enum logic [1:0] {ST_RESET, ST_SLEEP, ST_WAKE, ST_RUN} fsup_state_t;

  typedef struct packed {
    logic rd_status0;
    logic rd_short;
    logic rd_open;
    logic rd_thermal;
    logic rd_hr;
    logic wr_moten;
    logic moten_val;
    logic wr_sleep;
    logic sleep_val;
  } fsup_frame_req_t;

  typedef struct packed {
    logic stall;
    logic backemf_result_flag;
    logic uv_a;
    logic uv_b;
    logic uv_b_mask;
    logic uv_c;
    logic uv_c_mask;
  } fsup_aux_flags_t;

  typedef struct packed {
    logic stall_en;
    logic backemf_result_irq_en;
    logic undervolt_a_irq_en;
    logic undervolt_b_irq_en;
    logic undervolt_b_mask_irq_en;
    logic undervolt_c_irq_en;
    logic undervolt_c_mask_irq_en;
  } fsup_aux_en_t;

  typedef struct packed {
    logic [NUM_SHORT-1:0] short_flags;
    logic short_any;
    logic x_coil_disconnect_flag;
    logic y_coil_disconnect_flag;
    logic open_any;
    logic overtemp_warning;
    logic overtemp_shutdown;
    logic framing_error;
    logic reset_occurred_flag;
  } fsup_status_t;
endpackage

// File: fsup_spi_master.sv
`timescale 1ns/1ps
module fsup_spi_master (
  output logic spi_sclk,
  output logic spi_cs_n
);
  // The serial clock stands low between frames, as a real master leaves it.
  initial begin
    spi_sclk = 1'b0;
    spi_cs_n = 1'b1;
  end

  task automatic wake();
    spi_cs_n = 1'b0;
    #30;
    spi_cs_n = 1'b1;
    #60;
  endtask

  task automatic frame(input int n);
    spi_cs_n = 1'b0;
    #60;
    repeat (n) begin
      #6 spi_sclk = 1'b1;
      #6 spi_sclk = 1'b0;
    end
    #40 spi_cs_n = 1'b1;
  endtask
endmodule // fsup_spi_master

// File: fsup_supervisor.sv
`timescale 1ns/1ps
module fsup_supervisor
  import fsup_pkg::*;
#(
  parameter int HR_ERR_CYCLES = HR_ERR_CYC,
  parameter int WAKE_CYCLES = WAKE_CYC,
  parameter int OPEN_TMO0 = OPEN_TMO0_CYC,
  parameter int OPEN_TMO1 = OPEN_TMO1_CYC,
  parameter int OPEN_TMO2 = OPEN_TMO2_CYC,
  parameter int OPEN_TMO3 = OPEN_TMO3_CYC
) (
  input wire logic clock,
  input wire logic reset,
  input wire logic spi_sclk,
  input wire logic spi_cs_n,
  input wire logic [6:0] microstep_position,
  input wire logic [1:0] pwm_full_duty,
  input wire logic [1:0] open_det_sel,
  input wire logic disconnect_float_both,
  input wire logic disconnect_reaction_off,
  input wire logic auto_check_enable,
  input wire logic [NUM_SHORT-1:0] overcurrent_in,
  input wire logic overtemp_warn_in,
  input wire logic overtemp_shut_in,
  input wire logic dir_in,
  input wire logic run_hold_in,
  input wire logic run_hold_polarity,
  input wire fsup_aux_flags_t aux_flags,
  input wire fsup_aux_en_t aux_irq_en,
  input wire fsup_frame_req_t frame_req,
  output logic frame_commit,
  output logic frame_reject,
  output logic motor_enable,
  output logic [1:0] bridge_enable,
  output logic auto_check_start,
  output logic hold_active,
  output logic sleep_active,
  output fsup_status_t status,
  output logic fault_out_n_out,
  output logic fault_out_n_oe
);

  // Serial clock domain: a free-running gray count of rising edges, mod 16.
  logic [FRAME_W-1:0] sclk_bin_reg;
  logic [FRAME_W-1:0] sclk_gray_reg;
  logic [FRAME_W-1:0] sclk_bin_next;

  assign sclk_bin_next = sclk_bin_reg + 4'h1;

  // [RULE24] edge counting
  always_ff @(posedge spi_sclk or posedge reset) begin
    if (reset) begin
      sclk_bin_reg <= 4'h0;
      sclk_gray_reg <= 4'h0;
    end else begin
      sclk_bin_reg <= sclk_bin_next;
      sclk_gray_reg <= sclk_bin_next ^ (sclk_bin_next >> 1);
    end
  end

  // Three-stage synchronisers; a change counts once stages two and three agree.
  logic [SYNC_W-1:0] pin_raw;
  logic [SYNC_W-1:0] sync1_reg;
  logic [SYNC_W-1:0] sync2_reg;
  logic [SYNC_W-1:0] sync3_reg;
  logic [SYNC_W-1:0] pin_reg;

  assign pin_raw = {sclk_gray_reg, spi_cs_n, run_hold_in, dir_in, overtemp_shut_in,
                    overtemp_warn_in, overcurrent_in};

  genvar gi;
  generate
    for (gi = 0; gi < SYNC_W; gi++) begin : g_sync
      always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
          sync1_reg[gi] <= SYNC_RST[gi];
          sync2_reg[gi] <= SYNC_RST[gi];
          sync3_reg[gi] <= SYNC_RST[gi];
          pin_reg[gi] <= SYNC_RST[gi];
        end else begin
          sync1_reg[gi] <= pin_raw[gi];
          sync2_reg[gi] <= sync1_reg[gi];
          sync3_reg[gi] <= sync2_reg[gi];
          if (sync2_reg[gi] == sync3_reg[gi]) begin
            pin_reg[gi] <= sync3_reg[gi];
          end
        end
      end
    end
  endgenerate

  logic [NUM_SHORT-1:0] oc_f;
  logic warn_f;
  logic shut_f;
  logic dir_f;
  logic cs_f;
  logic [FRAME_W-1:0] gray_f;

  assign oc_f = pin_reg[SY_SHORT +: NUM_SHORT];
  assign warn_f = pin_reg[SY_WARN];
  assign shut_f = pin_reg[SY_SHUT];
  assign dir_f = pin_reg[SY_DIR];
  assign cs_f = pin_reg[SY_CS];
  assign gray_f = pin_reg[SY_GRAY +: FRAME_W];

  logic cs_prev_reg;
  logic dir_prev_reg;
  logic cs_fall;
  logic cs_rise;
  logic dir_rise;

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      cs_prev_reg <= 1'b1;
      dir_prev_reg <= 1'b0;
    end else begin
      cs_prev_reg <= cs_f;
      dir_prev_reg <= dir_f;
    end
  end

  assign cs_fall = cs_prev_reg & ~cs_f;
  assign cs_rise = ~cs_prev_reg & cs_f;
  assign dir_rise = ~dir_prev_reg & dir_f;

  // Sequencing: reset state, sleep, wake-up delay, run.
  fsup_state_t state_reg;
  logic [31:0] phase_cnt_reg;
  logic hr_fire;
  logic sleep_wr;
  logic frame_good_reg;
  logic run;
  logic dig_clr;
  logic thermal_live;

  assign run = (state_reg == ST_RUN);
  assign dig_clr = (state_reg == ST_RESET);
  // Thermal monitoring is frozen while asleep and resumes at wake-up.
  assign thermal_live = run | (state_reg == ST_WAKE);
  assign sleep_wr = frame_good_reg & frame_req.wr_sleep & frame_req.sleep_val;

  // [RULE18] [RULE21] reset and sleep sequence
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      state_reg <= ST_RESET;
      phase_cnt_reg <= 32'h0;
    end else begin
      phase_cnt_reg <= phase_cnt_reg + 32'h1;
      case (state_reg)
        ST_RESET: begin
          if (phase_cnt_reg == 32'(HR_ERR_CYCLES - 1)) begin
            state_reg <= ST_SLEEP;
          end
        end
        ST_SLEEP: begin
          phase_cnt_reg <= 32'h0;
          if (cs_fall) begin
            state_reg <= ST_WAKE;
          end
        end
        ST_WAKE: begin
          if (phase_cnt_reg == 32'(WAKE_CYCLES - 1)) begin
            state_reg <= ST_RUN;
          end
        end
        ST_RUN: begin
          phase_cnt_reg <= 32'h0;
          if (hr_fire) begin
            state_reg <= ST_RESET;
          end else if (sleep_wr) begin
            state_reg <= ST_SLEEP;
          end
        end
        default: begin
          state_reg <= ST_RESET;
          phase_cnt_reg <= 32'h0;
        end
      endcase
    end
  end

  // [RULE20] chip select wakes
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      sleep_active <= 1'b0;
    end else if (state_reg == ST_SLEEP && cs_fall) begin
      sleep_active <= 1'b0;
    end else if ((dig_clr && phase_cnt_reg == 32'(HR_ERR_CYCLES - 1)) || (run && sleep_wr)) begin
      sleep_active <= 1'b1;
    end
  end

  // Frame check: the gray count must return to its start value, i.e. 16*n edges.
  logic frame_open_reg;
  logic [FRAME_W-1:0] gray_start_reg;
  logic frame_bad;
  logic frame_ok;

  assign frame_ok = run & cs_rise & frame_open_reg & (gray_f == gray_start_reg);
  assign frame_bad = run & cs_rise & frame_open_reg & (gray_f != gray_start_reg);

  // [RULE24] frame boundaries
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      frame_open_reg <= 1'b0;
      gray_start_reg <= 4'h0;
    end else if (run && cs_fall) begin
      frame_open_reg <= 1'b1;
      gray_start_reg <= gray_f;
    end else if (cs_rise || !run) begin
      frame_open_reg <= 1'b0;
    end
  end

  // [RULE15] reject bad frames
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      frame_good_reg <= 1'b0;
      frame_commit <= 1'b0;
      frame_reject <= 1'b0;
    end else begin
      frame_good_reg <= frame_ok;
      frame_commit <= frame_ok;
      frame_reject <= frame_bad;
    end
  end

  logic framing_error_reg;

  // [RULE16] cleared by a clean status 0 read
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      framing_error_reg <= 1'b0;
    end else if (frame_bad) begin
      framing_error_reg <= 1'b1;
    end else if (dig_clr || (frame_good_reg && frame_req.rd_status0)) begin
      framing_error_reg <= 1'b0;
    end
  end

  // Open coil detection, one timer per coil.
  logic [1:0] bridge_en_reg;
  logic [1:0] coil_check;
  logic [1:0] open_hit;
  logic [1:0] open_flag_reg;
  logic [31:0] open_tmo;

  // [RULE2] expected coil only
  assign coil_check[0] = (microstep_position != MSP_Y0) && (microstep_position != MSP_Y1);
  assign coil_check[1] = (microstep_position != MSP_X0) && (microstep_position != MSP_X1);

  always_comb begin
    case (open_det_sel)
      2'h0: open_tmo = 32'(OPEN_TMO0);
      2'h1: open_tmo = 32'(OPEN_TMO1);
      2'h2: open_tmo = 32'(OPEN_TMO2);
      default: open_tmo = 32'(OPEN_TMO3);
    endcase
  end

  generate
    for (gi = 0; gi < 2; gi++) begin : g_coil
      logic [31:0] open_cnt_reg;
      logic watch;

      assign watch = run & bridge_en_reg[gi] & pwm_full_duty[gi] & coil_check[gi];
      assign open_hit[gi] = watch && (open_cnt_reg == open_tmo - 32'h1);

      // [RULE1] full duty timeout
      always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
          open_cnt_reg <= 32'h0;
        end else if (!watch) begin
          open_cnt_reg <= 32'h0;
        end else if (open_cnt_reg != open_tmo) begin
          open_cnt_reg <= open_cnt_reg + 32'h1;
        end
      end

      // [RULE3] per-coil open flag
      always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
          open_flag_reg[gi] <= 1'b0;
        end else if (open_hit[gi]) begin
          open_flag_reg[gi] <= 1'b1;
        end else if (dig_clr || (frame_good_reg && frame_req.rd_open)) begin
          open_flag_reg[gi] <= 1'b0;
        end
      end
    end
  endgenerate

  // Short detection on active stages of the coil expected to carry current.
  logic [NUM_SHORT-1:0] short_reg;
  logic [NUM_SHORT-1:0] short_set;
  logic [NUM_SHORT-1:0] short_next;
  logic short_any_reg;
  logic short_evt;
  logic [1:0] stage_watch;

  assign stage_watch = {2{run}} & bridge_en_reg & coil_check;
  assign short_set = oc_f & {{4{stage_watch[1]}}, {4{stage_watch[0]}}};
  assign short_evt = |short_set;

  // [RULE8] [RULE9] latched flags, read clears, set wins
  always_comb begin
    short_next = short_reg;
    if (dig_clr || (frame_good_reg && frame_req.rd_short)) begin
      short_next = '0;
    end
    short_next = short_next | short_set;
  end

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      short_reg <= '0;
      short_any_reg <= 1'b0;
    end else begin
      short_reg <= short_next;
      short_any_reg <= |short_next;
    end
  end

  // Thermal warning and shutdown.
  logic tw_reg;
  logic tsd_reg;
  logic tsd_read_reg;
  logic tsd_set;

  assign tsd_set = thermal_live & shut_f;

  // [RULE11] [RULE12] [RULE13] thermal flags
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      tw_reg <= 1'b0;
      tsd_reg <= 1'b0;
      tsd_read_reg <= 1'b0;
    end else begin
      if (thermal_live) begin
        tw_reg <= warn_f;
      end
      if (tsd_set) begin
        tsd_reg <= 1'b1;
        tsd_read_reg <= 1'b0;
      end else if (thermal_live && tsd_reg && tsd_read_reg && !warn_f) begin
        tsd_reg <= 1'b0;
        tsd_read_reg <= 1'b0;
      end else if (frame_good_reg && frame_req.rd_thermal && tsd_reg) begin
        tsd_read_reg <= 1'b1;
      end
    end
  end

  // Motor enable and bridge control.
  logic open_float;
  logic [1:0] open_single;
  logic moten_wr1;
  logic [1:0] bridge_off_reg;

  // [RULE6] reaction-off keeps drivers active
  assign open_float = (|open_hit) & disconnect_float_both & ~disconnect_reaction_off;
  assign open_single = open_hit & {2{~disconnect_float_both & ~disconnect_reaction_off}};
  // [RULE14] enable only without thermal flags
  assign moten_wr1 = frame_good_reg & frame_req.wr_moten & frame_req.moten_val & ~tsd_reg
                     & ~tw_reg;

  // [RULE5] [RULE7] [RULE12] protective clear beats a write
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      motor_enable <= 1'b0;
    end else if (dig_clr || short_evt || tsd_set || open_float) begin
      motor_enable <= 1'b0;
    end else if (frame_good_reg && frame_req.wr_moten && !frame_req.moten_val) begin
      motor_enable <= 1'b0;
    end else if (moten_wr1) begin
      motor_enable <= 1'b1;
    end
  end

  // [RULE4] only the affected bridge goes off
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      bridge_off_reg <= 2'h0;
    end else if (open_single != 2'h0) begin
      bridge_off_reg <= bridge_off_reg | open_single;
    end else if (dig_clr || moten_wr1) begin
      bridge_off_reg <= 2'h0;
    end
  end

  // [RULE19] bridges off unless running
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      bridge_en_reg <= 2'h0;
    end else begin
      bridge_en_reg <= {2{motor_enable & run & ~short_evt}} & ~bridge_off_reg;
    end
  end

  assign bridge_enable = bridge_en_reg;

  // [RULE10] diagnostics on enable rising edge
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      auto_check_start <= 1'b0;
    end else begin
      auto_check_start <= moten_wr1 & ~motor_enable & auto_check_enable & ~short_evt
                          & ~open_float & ~tsd_set & ~dig_clr;
    end
  end

  // Hard reset pattern on the direction input while in hold.
  logic hold_now;
  logic half_reg;
  logic [2:0] pat_cnt_reg;
  logic [TRIG_W-1:0] trig_cnt_reg;
  logic trig_late;

  // [RULE23] hold decode
  assign hold_now = ~(pin_reg[SY_RH] ^ run_hold_polarity);
  assign trig_late = (trig_cnt_reg == TRIG_W'(TRIG_CYC));
  assign hr_fire = run & hold_now & ~tsd_reg & dir_rise & half_reg & ~trig_late
                   & (pat_cnt_reg == HR_PATTERNS - 3'h1);

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      hold_active <= 1'b0;
    end else begin
      hold_active <= hold_now;
    end
  end

  // [RULE22] five timed patterns
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      half_reg <= 1'b0;
      pat_cnt_reg <= 3'h0;
      trig_cnt_reg <= '0;
    end else if (!run || !hold_now || tsd_reg || (half_reg && trig_late)) begin
      half_reg <= 1'b0;
      pat_cnt_reg <= 3'h0;
      trig_cnt_reg <= '0;
    end else if (dir_rise && !half_reg) begin
      half_reg <= 1'b1;
      trig_cnt_reg <= '0;
    end else if (dir_rise) begin
      half_reg <= 1'b0;
      pat_cnt_reg <= pat_cnt_reg + 3'h1;
    end else if (half_reg) begin
      trig_cnt_reg <= trig_cnt_reg + TRIG_W'(1);
    end
  end

  logic hr_flag_reg;

  // [RULE21] reset flag
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      hr_flag_reg <= 1'b0;
    end else if (dig_clr) begin
      hr_flag_reg <= 1'b1;
    end else if (frame_good_reg && frame_req.rd_hr) begin
      hr_flag_reg <= 1'b0;
    end
  end

  // Open-drain error output: the pin is only ever pulled low.
  logic err_any;

  // [RULE17] error combination
  assign err_any = framing_error_reg | short_any_reg | (|open_flag_reg) | tsd_reg | tw_reg
                   | (|(aux_flags & aux_irq_en)) | dig_clr;

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      fault_out_n_oe <= 1'b1;
    end else begin
      fault_out_n_oe <= err_any & (state_reg != ST_SLEEP);
    end
  end

  assign fault_out_n_out = 1'b0;

  always_comb begin
    status.short_flags = short_reg;
    status.short_any = short_any_reg;
    status.x_coil_disconnect_flag = open_flag_reg[0];
    status.y_coil_disconnect_flag = open_flag_reg[1];
    status.open_any = |open_flag_reg;
    status.overtemp_warning = tw_reg;
    status.overtemp_shutdown = tsd_reg;
    status.framing_error = framing_error_reg;
    status.reset_occurred_flag = hr_flag_reg;
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);

  property p_short_off;
    short_evt |=> !motor_enable ##1 (bridge_enable == 2'h0);
  endproperty
  a_short_off: assert property (p_short_off) else $error("short did not stop bridges"); // [RULE7]

  property p_open_single;
    open_hit[0] && !disconnect_float_both && !disconnect_reaction_off |=> ##1 !bridge_enable[0];
  endproperty
  a_open_single: assert property (p_open_single) else $error("open X bridge stayed on"); // [RULE4]

  property p_open_float;
    open_float |=> !motor_enable ##1 (bridge_enable == 2'h0);
  endproperty
  a_open_float: assert property (p_open_float) else $error("open float kept motor on"); // [RULE5]

  property p_moten_blocked;
    frame_good_reg && frame_req.wr_moten && (tsd_reg || tw_reg) && !motor_enable |=> !motor_enable;
  endproperty
  a_moten_blocked: assert property (p_moten_blocked) else $error("enable during overtemp"); // [RULE14]

  property p_sleep_quiet;
    (state_reg == ST_SLEEP) ##1 (state_reg == ST_SLEEP) |-> !fault_out_n_oe;
  endproperty
  a_sleep_quiet: assert property (p_sleep_quiet) else $error("error pin driven in sleep"); // [RULE17]

  property p_frame_bad;
    frame_bad |=> status.framing_error && frame_reject && !frame_commit;
  endproperty
  a_frame_bad: assert property (p_frame_bad) else $error("bad frame not flagged"); // [RULE15]

  property p_frame_clear;
    frame_commit && frame_req.rd_status0 && !frame_bad |=> !status.framing_error;
  endproperty
  a_frame_clear: assert property (p_frame_clear) else $error("framing flag not cleared"); // [RULE16]

  property p_reset_state;
    (state_reg == ST_RESET) |-> !sleep_active ##1 (fault_out_n_oe && status.reset_occurred_flag);
  endproperty
  a_reset_state: assert property (p_reset_state) else $error("reset state not shown"); // [RULE21]

  property p_wake;
    (state_reg == ST_SLEEP) && cs_fall |=> !sleep_active && (state_reg == ST_WAKE);
  endproperty
  a_wake: assert property (p_wake) else $error("chip select did not wake"); // [RULE20]

endmodule // fsup_supervisor

// File: tb.sv
`timescale 1ns/1ps
module tb;
  import fsup_pkg::*;
  logic clock, reset, spi_sclk, spi_cs_n, ok;
  logic [6:0] microstep_position;
  logic [1:0] pwm_full_duty, open_det_sel, bridge_enable;
  logic disconnect_float_both, disconnect_reaction_off, auto_check_enable;
  logic [7:0] overcurrent_in;
  logic overtemp_warn_in, overtemp_shut_in, dir_in, run_hold_in, run_hold_polarity;
  fsup_aux_flags_t aux_flags;
  fsup_aux_en_t aux_irq_en;
  fsup_frame_req_t frame_req, rq;
  logic frame_commit, frame_reject, motor_enable, auto_check_start, hold_active;
  logic sleep_active, fault_out_n_out, fault_out_n_oe;
  fsup_status_t status;
  int errors = 0;
  int n_checks = 0;
  int n_acs = 0;
  // The error pin is open drain with a pull-up.
  wire fault_pin = fault_out_n_oe ? fault_out_n_out : 1'b1;

  fsup_spi_master u_mst (.spi_sclk(spi_sclk), .spi_cs_n(spi_cs_n));
  fsup_supervisor #(.HR_ERR_CYCLES(50), .WAKE_CYCLES(20), .OPEN_TMO0(30),
    .OPEN_TMO1(60), .OPEN_TMO2(90)) u_dut (
    .clock(clock), .reset(reset), .spi_sclk(spi_sclk), .spi_cs_n(spi_cs_n),
    .microstep_position(microstep_position), .pwm_full_duty(pwm_full_duty),
    .open_det_sel(open_det_sel), .disconnect_float_both(disconnect_float_both),
    .disconnect_reaction_off(disconnect_reaction_off),
    .auto_check_enable(auto_check_enable), .overcurrent_in(overcurrent_in),
    .overtemp_warn_in(overtemp_warn_in), .overtemp_shut_in(overtemp_shut_in),
    .dir_in(dir_in), .run_hold_in(run_hold_in), .run_hold_polarity(run_hold_polarity),
    .aux_flags(aux_flags), .aux_irq_en(aux_irq_en), .frame_req(frame_req),
    .frame_commit(frame_commit), .frame_reject(frame_reject),
    .motor_enable(motor_enable), .bridge_enable(bridge_enable),
    .auto_check_start(auto_check_start), .hold_active(hold_active),
    .sleep_active(sleep_active), .status(status), .fault_out_n_out(fault_out_n_out),
    .fault_out_n_oe(fault_out_n_oe));

  initial begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end

  // Diagnostic start stands for one cycle only, so every pulse is counted here.
  always @(posedge clock) begin
    if (auto_check_start === 1'b1)
      n_acs++;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      errors++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic tally_and_finish();
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  task automatic settle();
    repeat (12) @(posedge clock);
  endtask

  task automatic run_frame(input fsup_frame_req_t r, input int n);
    int k;
    @(posedge clock);
    frame_req <= r;
    u_mst.frame(n);
    ok = 1'b0;
    for (k = 0; k < 20; k++) begin
      @(posedge clock);
      if (frame_commit === 1'b1) begin
        ok = 1'b1;
        break;
      end
      if (frame_reject === 1'b1)
        break;
    end
    if (k == 20) begin
      errors++;
      tally_and_finish();
    end
    @(posedge clock);
    frame_req <= '0;
  endtask

  initial begin
    {microstep_position, pwm_full_duty, open_det_sel, disconnect_float_both} = '0;
    {disconnect_reaction_off, auto_check_enable, overcurrent_in, overtemp_warn_in} = '0;
    {overtemp_shut_in, dir_in, run_hold_in, run_hold_polarity} = '0;
    aux_flags = '0;
    aux_irq_en = '0;
    frame_req = '0;
    reset = 1'b1;
    repeat (10) @(posedge clock);
    reset <= 1'b0;
    @(posedge clock);
    #1;
    chk(fault_pin, 1'b0);
    chk(status.reset_occurred_flag, 1'b1);
    repeat (60) @(posedge clock);
    chk(sleep_active, 1'b1);
    chk(fault_pin, 1'b1);
    $display("test reset done");
    u_mst.wake();
    repeat (40) @(posedge clock);
    chk(sleep_active, 1'b0);
    rq = '0;
    rq.wr_moten = 1'b1;
    rq.moten_val = 1'b1;
    run_frame(rq, 16);
    chk(ok, 1'b1);
    settle();
    chk(motor_enable, 1'b1);
    run_frame('0, 15);
    chk(ok, 1'b0);
    settle();
    chk(status.framing_error, 1'b1);
    chk(fault_pin, 1'b0);
    rq = '0;
    rq.rd_status0 = 1'b1;
    run_frame(rq, 32);
    settle();
    chk(status.framing_error, 1'b0);
    chk(fault_pin, 1'b1);
    $display("test frames done");
    @(posedge clock);
    overcurrent_in <= 8'h04;
    settle();
    chk(status.short_flags, 8'h04);
    chk(status.short_any, 1'b1);
    chk({motor_enable, bridge_enable}, 3'h0);
    overcurrent_in <= 8'h00;
    rq = '0;
    rq.rd_short = 1'b1;
    run_frame(rq, 16);
    settle();
    chk(status.short_any, 1'b0);
    $display("test short done");
    auto_check_enable <= 1'b1;
    rq = '0;
    rq.wr_moten = 1'b1;
    rq.moten_val = 1'b1;
    run_frame(rq, 16);
    settle();
    chk(bridge_enable, 2'h3);
    pwm_full_duty <= 2'h1;
    repeat (40) @(posedge clock);
    chk(status.x_coil_disconnect_flag, 1'b1);
    chk(status.open_any, 1'b1);
    chk({motor_enable, bridge_enable}, 3'h6);
    pwm_full_duty <= 2'h0;
    microstep_position <= 7'h20;
    open_det_sel <= 2'h1;
    disconnect_float_both <= 1'b1;
    rq.rd_open = 1'b1;
    run_frame(rq, 16);
    pwm_full_duty <= 2'h3;
    repeat (45) @(posedge clock);
    chk(status.y_coil_disconnect_flag, 1'b0);
    repeat (25) @(posedge clock);
    chk(status.y_coil_disconnect_flag, 1'b1);
    chk(status.x_coil_disconnect_flag, 1'b0);
    chk({motor_enable, bridge_enable}, 3'h0);
    disconnect_reaction_off <= 1'b1;
    run_frame(rq, 16);
    repeat (70) @(posedge clock);
    chk(status.y_coil_disconnect_flag, 1'b1);
    chk({motor_enable, bridge_enable}, 3'h7);
    chk(n_acs, 2);
    pwm_full_duty <= 2'h0;
    rq = '0;
    rq.rd_open = 1'b1;
    run_frame(rq, 16);
    settle();
    chk(fault_pin, 1'b1);
    $display("test open done");
    overtemp_warn_in <= 1'b1;
    settle();
    chk(status.overtemp_warning, 1'b1);
    chk(fault_pin, 1'b0);
    chk(motor_enable, 1'b1);
    overtemp_shut_in <= 1'b1;
    settle();
    chk(status.overtemp_shutdown, 1'b1);
    chk(motor_enable, 1'b0);
    overtemp_shut_in <= 1'b0;
    rq = '0;
    rq.wr_moten = 1'b1;
    rq.moten_val = 1'b1;
    rq.rd_thermal = 1'b1;
    rq.rd_hr = 1'b1;
    run_frame(rq, 16);
    settle();
    chk(motor_enable, 1'b0);
    chk(status.overtemp_shutdown, 1'b1);
    overtemp_warn_in <= 1'b0;
    settle();
    chk(status.overtemp_shutdown, 1'b0);
    chk(fault_pin, 1'b1);
    $display("test thermal done");
    chk(hold_active, 1'b1);
    run_hold_polarity <= 1'b1;
    settle();
    chk(hold_active, 1'b0);
    run_hold_polarity <= 1'b0;
    settle();
    repeat (20) begin
      dir_in <= ~dir_in;
      repeat (6) @(posedge clock);
    end
    chk(fault_pin, 1'b0);
    chk(status.reset_occurred_flag, 1'b1);
    repeat (60) @(posedge clock);
    chk(sleep_active, 1'b1);
    $display("test hard reset done");
    tally_and_finish();
  end

  initial begin
    #200000;
    errors++;
    tally_and_finish();
  end
endmodule // tb
